// *** core/ssc_pkg.sv ***
// constants for the system support control register bank
// What this block does
// RULE_01 - per-quarter parity generate/check, odd selectable
// RULE_02 - strobes and address may float when enabled
// RULE_03 - extension bit widens I/O ready generation
// RULE_04 - spare I/O bit makes spare spaces legal
// RULE_05 - bit reports error correction in use
// RULE_06 - two enables for unimplemented memory blocks
// RULE_07 - flag PIO commands beyond first-unused limits
// RULE_08 - long I/O ready, 1-15 ms, low ranges
// RULE_09 - long memory ready, 1-15 ms, lowest quarter
// RULE_10 - status shows three built-in test passes
// RULE_11 - watchdog terminal count sets status flag
// RULE_12 - bus time-out terminal count sets flag
// RULE_13 - status flag mirrors last interrupt command
// RULE_14 - memory wait register, four counts, resets FFFF
// RULE_15 - I/O wait register, four section counts
// RULE_16 - software programs clock MHz field
// RULE_17 - time-out limit 128 or 64 cycles
// RULE_18 - watchdog ticks at 1 kHz or 1 MHz
// RULE_19 - software loads 16-bit watchdog count
// RULE_20 - two low/high boundary pairs bound blocks
// RULE_21 - command limits held in bits 6-15; the code keeps them in bits 0-9
// RULE_22 - capture low address of first failure
// RULE_23 - watchdog counts down from set-up count
// RULE_24 - time-out counts cycles of outstanding access
package ssc_pkg;
  // byte offsets on the register bus
  localparam logic [5:0] OFS_CONTROL = 6'h00;
  localparam logic [5:0] OFS_STATUS = 6'h04;
  localparam logic [5:0] OFS_MEM_WAIT = 6'h08;
  localparam logic [5:0] OFS_IO_WAIT = 6'h0C;
  localparam logic [5:0] OFS_TIMING = 6'h10;
  localparam logic [5:0] OFS_WATCHDOG = 6'h14;
  localparam logic [5:0] OFS_UNIMPL = 6'h18;
  localparam logic [5:0] OFS_OUT_CMD = 6'h1C;
  localparam logic [5:0] OFS_IN_CMD = 6'h20;
  localparam logic [5:0] OFS_FIRST_FAIL = 6'h24;
  // control bits (register bit 15 is the leftmost field)
  localparam int CTL_PARITY_EN_Q1 = 15;
  localparam int CTL_ODD = 11;
  localparam int CTL_STROBE_FLOAT_EN = 10;
  localparam int CTL_ADDRESS_FLOAT_EN = 9;
  localparam int CTL_READY_FULL_SPACE_EN = 8;
  localparam int CTL_SPARE_IO_LEGAL = 7;
  localparam int CTL_EDAC_IN_USE = 6;
  localparam int CTL_UNIMPL_BLOCK_A_EN = 5;
  localparam int CTL_UNIMPL_BLOCK_B_EN = 4;
  localparam int CTL_ILLEGAL_IO_DETECT_EN = 3;
  localparam int CTL_LONG_IO_READY_EN = 2;
  localparam int CTL_LONG_MEM_READY_EN = 1;
  // status bits
  localparam int STS_CPU_PASS = 15;
  localparam int STS_COMPANION_TEST_PASS = 14;
  localparam int STS_SUPPORT_CTRL_TEST_PASS = 13;
  localparam int STS_WATCHDOG_EXPIRED = 8;
  localparam int STS_BUS_TIMEOUT_EXPIRED = 7;
  localparam int STS_LAST_INTERRUPT_CMD_FLAG = 0;
  // timing program fields
  localparam int TIM_CLOCK_MHZ_LSB = 10;
  localparam int TIM_BUS_TIMEOUT_EN = 9;
  localparam int TIM_BUS_TIMEOUT_LIMIT_SEL = 8;
  localparam int TIM_WATCHDOG_EN = 7;
  localparam int TIM_WATCHDOG_SLOW_SEL = 6;
  // reset values
  localparam logic [15:0] RST_CONTROL = 16'h0000;
  localparam logic [15:0] RST_MEM_WAIT = 16'hFFFF;
  localparam logic [15:0] RST_IO_WAIT = 16'h0000;
  localparam logic [15:0] RST_TIMING = 16'h0000;
  localparam logic [15:0] RST_WATCHDOG = 16'h0000;
  localparam logic [15:0] RST_UNIMPL = 16'h0000;
  localparam logic [9:0] RST_CMD_LIMIT = 10'h3FF;
  // timing counts
  localparam logic [7:0] BUS_TMO_SHORT = 8'h40;
  localparam logic [7:0] BUS_TMO_LONG = 8'h80;
  localparam logic [9:0] US_PER_MS = 10'h3E8;
  // spare I/O space: upper nibble of the command address
  localparam logic [3:0] SPARE_IO_NIBBLE = 4'h7;
  // bus cycle states
  typedef enum logic [1:0] {
    SSC_IDLE = 2'b00,
    SSC_WAIT = 2'b01,
    SSC_LONG = 2'b10,
    SSC_EXT = 2'b11
  } ssc_state_t;
endpackage : ssc_pkg

// *** core/ssc_regs.sv ***
// system support control register bank with bus cycle timing
`timescale 1ns/1ps
module ssc_regs
  import ssc_pkg::*;
(
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  // avalon-mm register slave
  input wire logic [5:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  // processor bus cycle request
  input wire logic i_cyc_start,
  input wire logic i_cyc_mem,
  input wire logic i_cyc_rd,
  input wire logic [15:0] i_cyc_addr,
  input wire logic [15:0] i_cyc_wdata,
  input wire logic [15:0] i_mem_rdata,
  input wire logic i_mem_rpar,
  input wire logic i_ext_ready,
  output logic o_ready,
  output logic o_cyc_idle,
  // generated strobes and address
  output logic o_io_read_strobe,
  output logic o_io_write_strobe,
  output logic o_mem_read_strobe,
  output logic o_mem_write_strobe,
  output logic o_strobe_oe,
  output logic [15:0] o_addr,
  output logic o_addr_oe,
  output logic o_mem_wpar,
  // faults and side signals
  output logic o_parity_err,
  output logic o_unimpl_mem,
  output logic o_illegal_io,
  output logic o_bus_timeout,
  output logic o_edac_in_use,
  // built-in test and interrupt command reports
  input wire logic i_bist_done,
  input wire logic i_cpu_test_pass,
  input wire logic i_companion_test_pass,
  input wire logic i_support_ctrl_test_pass,
  input wire logic i_int_cmd_valid,
  input wire logic i_int_cmd_flag
);

  // address falls inside a 4k-granular block
  function automatic logic in_block(input logic [3:0] a, input logic [3:0] lo,
                                    input logic [3:0] hi);
    in_block = (a >= lo) && (a <= hi);
  endfunction : in_block

  logic [15:0] control_reg, mem_wait_reg, io_wait_reg, timing_reg, watchdog_reg;
  logic [15:0] unimpl_reg, first_fail_reg;
  logic [9:0] out_cmd_reg, in_cmd_reg;
  logic [2:0] test_pass_reg;
  logic watchdog_expired_reg, bus_timeout_expired_reg, int_flag_reg;
  logic ack_reg, fail_locked_reg;
  logic [31:0] rdata_reg;
  logic wr_go, rd_go;

  // answer one cycle after the request; the hold keeps the master stable
  assign o_avs_waitrequest = (i_avs_read | i_avs_write) & ~ack_reg;
  assign wr_go = i_avs_write & ack_reg;
  assign rd_go = i_avs_read & ack_reg;
  assign o_avs_readdata = rdata_reg;

  // acknowledge toggles so back-to-back requests each get a wait cycle
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= (i_avs_read | i_avs_write) & ~ack_reg;
    end
  end

  // merge low two byte lanes into a 16-bit register
  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [31:0] wd, input logic [3:0] be);
    merge16 = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
  endfunction : merge16

  // same merge for the ten-bit command limits
  function automatic logic [9:0] merge10(input logic [9:0] old,
                                         input logic [31:0] wd, input logic [3:0] be);
    merge10 = {be[1] ? wd[9:8] : old[9:8], be[0] ? wd[7:0] : old[7:0]};
  endfunction : merge10

  // software-written registers
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      control_reg <= RST_CONTROL;
      // RULE_14 all-ones reset
      mem_wait_reg <= RST_MEM_WAIT;
      io_wait_reg <= RST_IO_WAIT;
      timing_reg <= RST_TIMING;
      watchdog_reg <= RST_WATCHDOG;
      unimpl_reg <= RST_UNIMPL;
      out_cmd_reg <= RST_CMD_LIMIT;
      in_cmd_reg <= RST_CMD_LIMIT;
    end else if (wr_go) begin
      case (i_avs_address)
        OFS_CONTROL: control_reg <= merge16(control_reg, i_avs_writedata, i_avs_byteenable)
                                    & 16'hFFFE;
        OFS_MEM_WAIT: mem_wait_reg <= merge16(mem_wait_reg, i_avs_writedata, i_avs_byteenable);
        OFS_IO_WAIT: io_wait_reg <= merge16(io_wait_reg, i_avs_writedata, i_avs_byteenable);
        OFS_TIMING: timing_reg <= merge16(timing_reg, i_avs_writedata, i_avs_byteenable)
                                  & 16'hFFC0;
        OFS_WATCHDOG: watchdog_reg <= merge16(watchdog_reg, i_avs_writedata, i_avs_byteenable);
        OFS_UNIMPL: unimpl_reg <= merge16(unimpl_reg, i_avs_writedata, i_avs_byteenable);
        // RULE_21 limits in low ten bits
        OFS_OUT_CMD: out_cmd_reg <= merge10(out_cmd_reg, i_avs_writedata, i_avs_byteenable);
        OFS_IN_CMD: in_cmd_reg <= merge10(in_cmd_reg, i_avs_writedata, i_avs_byteenable);
        default: ;
      endcase
    end
  end

  // read mux, loaded in the wait cycle
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rdata_reg <= 32'h0000_0000;
    end else if (i_avs_read & ~ack_reg) begin
      case (i_avs_address)
        OFS_CONTROL: rdata_reg <= {16'h0000, control_reg};
        // RULE_10 test passes in status
        OFS_STATUS: rdata_reg <= {16'h0000, test_pass_reg, 4'h0,
                                  watchdog_expired_reg, bus_timeout_expired_reg, 6'h00,
                                  int_flag_reg};
        OFS_MEM_WAIT: rdata_reg <= {16'h0000, mem_wait_reg};
        OFS_IO_WAIT: rdata_reg <= {16'h0000, io_wait_reg};
        OFS_TIMING: rdata_reg <= {16'h0000, timing_reg};
        OFS_WATCHDOG: rdata_reg <= {16'h0000, watchdog_reg};
        OFS_UNIMPL: rdata_reg <= {16'h0000, unimpl_reg};
        OFS_OUT_CMD: rdata_reg <= {22'h000000, out_cmd_reg};
        OFS_IN_CMD: rdata_reg <= {22'h000000, in_cmd_reg};
        OFS_FIRST_FAIL: rdata_reg <= {16'h0000, first_fail_reg};
        default: rdata_reg <= 32'h0000_0000;
      endcase
    end
  end

  // control fields
  logic odd_sel, strobe_float_en, address_float_en, ready_full_space_en;
  logic spare_io_legal, unimpl_block_a_en, unimpl_block_b_en;
  logic illegal_io_detect_en, long_io_ready_en, long_mem_ready_en;
  logic [5:0] clock_mhz_field;
  logic bus_timeout_en, bus_timeout_limit_sel, watchdog_en, watchdog_slow_sel;
  assign odd_sel = control_reg[CTL_ODD];
  assign strobe_float_en = control_reg[CTL_STROBE_FLOAT_EN];
  assign address_float_en = control_reg[CTL_ADDRESS_FLOAT_EN];
  assign ready_full_space_en = control_reg[CTL_READY_FULL_SPACE_EN];
  assign spare_io_legal = control_reg[CTL_SPARE_IO_LEGAL];
  assign unimpl_block_a_en = control_reg[CTL_UNIMPL_BLOCK_A_EN];
  assign unimpl_block_b_en = control_reg[CTL_UNIMPL_BLOCK_B_EN];
  assign illegal_io_detect_en = control_reg[CTL_ILLEGAL_IO_DETECT_EN];
  assign long_io_ready_en = control_reg[CTL_LONG_IO_READY_EN];
  assign long_mem_ready_en = control_reg[CTL_LONG_MEM_READY_EN];
  // RULE_05 configuration bit out
  assign o_edac_in_use = control_reg[CTL_EDAC_IN_USE];
  // RULE_16 clock field used as microsecond divider
  assign clock_mhz_field = timing_reg[TIM_CLOCK_MHZ_LSB +: 6];
  assign bus_timeout_en = timing_reg[TIM_BUS_TIMEOUT_EN];
  assign bus_timeout_limit_sel = timing_reg[TIM_BUS_TIMEOUT_LIMIT_SEL];
  assign watchdog_en = timing_reg[TIM_WATCHDOG_EN];
  assign watchdog_slow_sel = timing_reg[TIM_WATCHDOG_SLOW_SEL];

  // microsecond and millisecond ticks; a zero field divides by one
  logic [5:0] us_div_reg;
  logic [9:0] ms_div_reg;
  logic us_tick, ms_tick;
  assign us_tick = (us_div_reg == 6'h00);
  assign ms_tick = us_tick && (ms_div_reg == 10'h000);
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      us_div_reg <= 6'h00;
      ms_div_reg <= 10'h000;
    end else begin
      us_div_reg <= us_tick ? (clock_mhz_field - 6'h01) & {6{|clock_mhz_field}}
                            : us_div_reg - 6'h01;
      if (us_tick) begin
        ms_div_reg <= (ms_div_reg == 10'h000) ? US_PER_MS - 10'h001 : ms_div_reg - 10'h001;
      end
    end
  end

  // decode of the pending cycle
  ssc_state_t state_reg;
  logic [15:0] cyc_addr_reg, cyc_wdata_reg;
  logic cyc_mem_reg, cyc_rd_reg;
  logic [1:0] quarter;
  logic [3:0] wait_sel;
  logic go_long, io_generated, unimpl_hit, illegal_hit, par_en;
  assign quarter = i_cyc_addr[15:14];
  // RULE_15 RULE_14 per-quarter wait counts
  assign wait_sel = i_cyc_mem ? mem_wait_reg[15 - 4 * quarter -: 4]
                              : io_wait_reg[15 - 4 * quarter -: 4];
  // RULE_08 RULE_09 long ready ranges
  assign go_long = i_cyc_mem ? (long_mem_ready_en && quarter == 2'b00)
                             : (long_io_ready_en && i_cyc_addr[14:8] == 7'h00);
  // RULE_03 limited range unless extended
  assign io_generated = ready_full_space_en || (i_cyc_addr[14:12] == 3'b000);
  // RULE_06 RULE_20 enabled blocks with bounds
  assign unimpl_hit = i_cyc_mem && (
      (unimpl_block_a_en && in_block(i_cyc_addr[15:12], unimpl_reg[15:12], unimpl_reg[11:8]))
   || (unimpl_block_b_en && in_block(i_cyc_addr[15:12], unimpl_reg[7:4], unimpl_reg[3:0])));
  // RULE_07 RULE_04 command limits and spare space
  assign illegal_hit = !i_cyc_mem && illegal_io_detect_en && (
      (i_cyc_addr[9:0] >= (i_cyc_rd ? in_cmd_reg : out_cmd_reg))
   || (!spare_io_legal && i_cyc_addr[15:12] == SPARE_IO_NIBBLE));
  // RULE_01 quarter enable for the latched address
  assign par_en = cyc_mem_reg && control_reg[CTL_PARITY_EN_Q1 - {30'd0, cyc_addr_reg[15:14]}];

  // bus cycle sequencer
  logic [7:0] tmo_cnt_reg;
  logic [3:0] wait_cnt_reg;
  logic [3:0] ms_left_reg;
  logic tmo_hit, done_now;
  // RULE_17 RULE_24 limit on an outstanding cycle
  assign tmo_hit = bus_timeout_en && state_reg != SSC_IDLE
                && tmo_cnt_reg == (bus_timeout_limit_sel ? BUS_TMO_LONG : BUS_TMO_SHORT) - 8'h01;
  assign done_now = !tmo_hit && (
      (state_reg == SSC_WAIT && wait_cnt_reg == 4'h0)
   || (state_reg == SSC_LONG && ms_tick && ms_left_reg == 4'h1)
   || (state_reg == SSC_EXT && i_ext_ready));
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_reg <= SSC_IDLE;
      wait_cnt_reg <= 4'h0;
      ms_left_reg <= 4'h0;
      tmo_cnt_reg <= 8'h00;
      cyc_addr_reg <= 16'h0000;
      cyc_wdata_reg <= 16'h0000;
      cyc_mem_reg <= 1'b0;
      cyc_rd_reg <= 1'b0;
    end else begin
      tmo_cnt_reg <= (state_reg == SSC_IDLE) ? 8'h00 : tmo_cnt_reg + 8'h01;
      case (state_reg)
        SSC_IDLE: begin
          if (i_cyc_start) begin
            cyc_addr_reg <= i_cyc_addr;
            cyc_wdata_reg <= i_cyc_wdata;
            cyc_mem_reg <= i_cyc_mem;
            cyc_rd_reg <= i_cyc_rd;
            wait_cnt_reg <= wait_sel;
            ms_left_reg <= (wait_sel == 4'h0) ? 4'h1 : wait_sel;
            if (go_long) begin
              state_reg <= SSC_LONG;
            end else if (i_cyc_mem || io_generated) begin
              state_reg <= SSC_WAIT;
            end else begin
              state_reg <= SSC_EXT;
            end
          end
        end
        SSC_WAIT: begin
          wait_cnt_reg <= wait_cnt_reg - 4'h1;
          if (tmo_hit || done_now) state_reg <= SSC_IDLE;
        end
        SSC_LONG: begin
          if (ms_tick) ms_left_reg <= ms_left_reg - 4'h1;
          if (tmo_hit || done_now) state_reg <= SSC_IDLE;
        end
        SSC_EXT: begin
          if (tmo_hit || done_now) state_reg <= SSC_IDLE;
        end
        default: state_reg <= SSC_IDLE;
      endcase
    end
  end

  // cycle outputs; unimplemented and illegal faults are reported with the cycle start
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_ready <= 1'b0;
      o_bus_timeout <= 1'b0;
      o_parity_err <= 1'b0;
      o_unimpl_mem <= 1'b0;
      o_illegal_io <= 1'b0;
    end else begin
      o_ready <= done_now;
      o_bus_timeout <= tmo_hit;
      o_unimpl_mem <= state_reg == SSC_IDLE && i_cyc_start && unimpl_hit;
      o_illegal_io <= state_reg == SSC_IDLE && i_cyc_start && illegal_hit;
      // RULE_01 check read parity at completion
      o_parity_err <= done_now && par_en && cyc_rd_reg
                   && ((^i_mem_rdata ^ i_mem_rpar) != odd_sel);
    end
  end

  // strobes and address; floating hands the pins to another master
  assign o_cyc_idle = (state_reg == SSC_IDLE);
  assign o_io_read_strobe = !o_cyc_idle && !cyc_mem_reg && cyc_rd_reg;
  assign o_io_write_strobe = !o_cyc_idle && !cyc_mem_reg && !cyc_rd_reg;
  assign o_mem_read_strobe = !o_cyc_idle && cyc_mem_reg && cyc_rd_reg;
  assign o_mem_write_strobe = !o_cyc_idle && cyc_mem_reg && !cyc_rd_reg;
  assign o_addr = cyc_addr_reg;
  // RULE_02 float controls
  assign o_strobe_oe = !strobe_float_en;
  assign o_addr_oe = !address_float_en;
  // RULE_01 generated parity, odd makes the count of ones odd
  assign o_mem_wpar = par_en && !cyc_rd_reg && ((^cyc_wdata_reg) ^ odd_sel);

  // first failure capture, re-armed by reading the capture register
  logic any_fail;
  assign any_fail = o_parity_err | o_unimpl_mem | o_illegal_io | o_bus_timeout;
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      first_fail_reg <= 16'h0000;
      fail_locked_reg <= 1'b0;
    end else if (any_fail && !fail_locked_reg) begin
      // RULE_22 low address of first failure
      first_fail_reg <= cyc_addr_reg;
      fail_locked_reg <= 1'b1;
    end else if (rd_go && i_avs_address == OFS_FIRST_FAIL) begin
      fail_locked_reg <= 1'b0;
    end
  end

  // watchdog down-counter, reloaded by writing its register
  logic [15:0] wd_cnt_reg;
  logic wd_tick;
  // RULE_18 tick select
  assign wd_tick = watchdog_slow_sel ? ms_tick : us_tick;
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wd_cnt_reg <= 16'h0000;
    end else if (wr_go && i_avs_address == OFS_WATCHDOG) begin
      // RULE_19 software set-up count
      wd_cnt_reg <= merge16(watchdog_reg, i_avs_writedata, i_avs_byteenable);
    end else if (watchdog_en && wd_tick && wd_cnt_reg != 16'h0000) begin
      // RULE_23 count toward terminal count
      wd_cnt_reg <= wd_cnt_reg - 16'h0001;
    end
  end

  // sticky expiry flags, cleared by reading status, a new event wins; interrupt flag and test passes are not cleared
  logic st_clr;
  assign st_clr = rd_go && i_avs_address == OFS_STATUS;
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      watchdog_expired_reg <= 1'b0;
      bus_timeout_expired_reg <= 1'b0;
      int_flag_reg <= 1'b0;
      test_pass_reg <= 3'b000;
    end else begin
      // RULE_11 watchdog terminal count
      if (watchdog_en && wd_tick && wd_cnt_reg == 16'h0001) begin
        watchdog_expired_reg <= 1'b1;
      end else if (st_clr) begin
        watchdog_expired_reg <= 1'b0;
      end
      // RULE_12 time-out terminal count
      if (tmo_hit) begin
        bus_timeout_expired_reg <= 1'b1;
      end else if (st_clr) begin
        bus_timeout_expired_reg <= 1'b0;
      end
      // RULE_13 last interrupt command
      if (i_int_cmd_valid) int_flag_reg <= i_int_cmd_flag;
      // RULE_10 latch test results
      if (i_bist_done) begin
        test_pass_reg <= {i_cpu_test_pass, i_companion_test_pass, i_support_ctrl_test_pass};
      end
    end
  end

  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);

  property p_tmo_flag;
    tmo_hit |=> bus_timeout_expired_reg && o_bus_timeout && state_reg == SSC_IDLE;
  endproperty
  a_tmo_flag: assert property (p_tmo_flag) else $error("time-out flag missing"); // RULE_12

  property p_tmo_limit;
    tmo_hit |-> bus_timeout_limit_sel || ($past(o_cyc_idle, 64) && !$past(o_cyc_idle, 63));
  endproperty
  a_tmo_limit: assert property (p_tmo_limit) else $error("time-out limit wrong"); // RULE_17

  property p_wd_flag;
    watchdog_en && wd_tick && wd_cnt_reg == 16'h0001 && !wr_go |=> watchdog_expired_reg;
  endproperty
  a_wd_flag: assert property (p_wd_flag) else $error("watchdog flag missing"); // RULE_11

  property p_wd_hold;
    !watchdog_en && !wr_go |=> $stable(wd_cnt_reg);
  endproperty
  a_wd_hold: assert property (p_wd_hold) else $error("watchdog moved while off"); // RULE_23

  property p_float;
    strobe_float_en |-> !o_strobe_oe;
  endproperty
  a_float: assert property (p_float) else $error("strobes driven while floating"); // RULE_02

  property p_wait_len;
    state_reg == SSC_IDLE && i_cyc_start && !go_long && i_cyc_mem && wait_sel == 4'h2
      && !bus_timeout_en |-> ##4 o_ready ##1 !o_ready;
  endproperty
  a_wait_len: assert property (p_wait_len) else $error("wait states wrong"); // RULE_14

  property p_unimpl;
    state_reg == SSC_IDLE && i_cyc_start && i_cyc_mem && !unimpl_block_a_en
      && !unimpl_block_b_en |=> !o_unimpl_mem;
  endproperty
  a_unimpl: assert property (p_unimpl) else $error("unimplemented flag while off"); // RULE_06

  property p_illegal;
    state_reg == SSC_IDLE && i_cyc_start && !illegal_io_detect_en |=> !o_illegal_io;
  endproperty
  a_illegal: assert property (p_illegal) else $error("illegal I/O while off"); // RULE_07

  property p_capture;
    any_fail && !fail_locked_reg |=> first_fail_reg == $past(cyc_addr_reg) && fail_locked_reg;
  endproperty
  a_capture: assert property (p_capture) else $error("first failure not captured"); // RULE_22

  property p_int;
    i_int_cmd_valid |=> int_flag_reg == $past(i_int_cmd_flag);
  endproperty
  a_int: assert property (p_int) else $error("interrupt flag wrong"); // RULE_13

endmodule : ssc_regs

// *** verification/ssc_cpu_model.sv ***
// processor core model that issues memory and i/o bus cycles
`timescale 1ns/1ps
module ssc_cpu_model (
  // clock and cycle results
  input wire logic i_clk_sys,
  input wire logic i_ready,
  input wire logic i_timeout,
  input wire logic i_perr,
  // cycle request and returned memory data
  output logic o_start,
  output logic o_mem,
  output logic o_rd,
  output logic [15:0] o_addr,
  output logic [15:0] o_rdata,
  output logic o_rpar,
  output logic o_ext_ready
);
  initial begin
    o_start = 1'b0;
    o_mem = 1'b0;
    o_rd = 1'b0;
    o_addr = 16'h0000;
    o_rdata = 16'h0000;
    o_rpar = 1'b0;
    o_ext_ready = 1'b0;
  end
  // one read cycle; n counts edges until ready or time-out is seen
  task automatic run(input logic m, input logic [15:0] a, input logic [15:0] d,
                     input logic p, output int n, output logic tmo, output logic perr);
    n = 0;
    @(posedge i_clk_sys);
    o_start <= 1'b1;
    o_mem <= m;
    o_rd <= 1'b1;
    o_addr <= a;
    o_rdata <= d;
    o_rpar <= p;
    do begin
      @(posedge i_clk_sys);
      o_start <= 1'b0;
      n++;
    end while (i_ready !== 1'b1 && i_timeout !== 1'b1 && n < 300);
    tmo = i_timeout;
    perr = i_perr;
    // released data no longer shows the last value
    o_rdata <= ~d;
    o_rpar <= ~p;
  endtask : run
endmodule : ssc_cpu_model

// *** verification/test_ssc_regs.sv ***
// self-checking bench for the support controller register bank
`timescale 1ns/1ps
module test_ssc_regs;
  import ssc_pkg::*;
  logic i_clk_sys, i_rst_n, rd, wr, bist, icv, start, mem, crd, rpar, xrdy;
  logic o_avs_waitrequest, o_ready, o_bus_timeout, o_parity_err;
  logic o_strobe_oe, o_addr_oe, o_edac_in_use, tmo, pe;
  logic [5:0] adr;
  logic [31:0] wdat, rdat;
  logic [15:0] caddr, mrd, q;
  int mismatches, samples_checked, cycles, n;
  ssc_regs u_ssc_regs (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_avs_address(adr),
    .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdat), .i_avs_byteenable(4'hF),
    .o_avs_readdata(rdat), .o_avs_waitrequest(o_avs_waitrequest), .i_cyc_start(start),
    .i_cyc_mem(mem), .i_cyc_rd(crd), .i_cyc_addr(caddr), .i_cyc_wdata(16'h0000),
    .i_mem_rdata(mrd), .i_mem_rpar(rpar), .i_ext_ready(xrdy), .o_ready(o_ready),
    .o_cyc_idle(), .o_io_read_strobe(), .o_io_write_strobe(), .o_mem_read_strobe(),
    .o_mem_write_strobe(), .o_strobe_oe(o_strobe_oe), .o_addr(), .o_addr_oe(o_addr_oe),
    .o_mem_wpar(), .o_parity_err(o_parity_err), .o_unimpl_mem(), .o_illegal_io(),
    .o_bus_timeout(o_bus_timeout), .o_edac_in_use(o_edac_in_use), .i_bist_done(bist),
    .i_cpu_test_pass(bist), .i_companion_test_pass(bist),
    .i_support_ctrl_test_pass(bist), .i_int_cmd_valid(icv), .i_int_cmd_flag(icv));
  ssc_cpu_model u_ssc_cpu_model (.i_clk_sys(i_clk_sys), .i_ready(o_ready),
    .i_timeout(o_bus_timeout), .i_perr(o_parity_err), .o_start(start), .o_mem(mem),
    .o_rd(crd), .o_addr(caddr),
    .o_rdata(mrd), .o_rpar(rpar), .o_ext_ready(xrdy));
  // one compare for every 16-bit result
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    samples_checked++;
    if (g !== e) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // avalon transfer held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [5:0] a, input logic [15:0] d);
    @(posedge i_clk_sys);
    rd <= ~w;
    wr <= w;
    adr <= a;
    wdat <= {16'h0000, d};
    do @(posedge i_clk_sys); while (o_avs_waitrequest !== 1'b0);
    q = rdat[15:0];
    rd <= 1'b0;
    wr <= 1'b0;
  endtask : bus
  task automatic t_reset();
    bus(0, OFS_MEM_WAIT, 0); chk("memwait", 16'hFFFF, q);
    bus(0, OFS_WATCHDOG, 0); chk("watchdog", 16'h0000, q);
    bus(0, 6'h3C, 0); chk("unmapped", 16'h0000, q);
  endtask : t_reset
  task automatic t_control();
    bus(1, OFS_CONTROL, 16'hFFFF);
    bus(0, OFS_CONTROL, 0); chk("control", 16'hFFFE, q);
    chk("edac", 16'h0001, {15'h0000, o_edac_in_use});
    chk("oe", 16'h0000, {o_strobe_oe, o_addr_oe});
    bus(1, OFS_CONTROL, 16'h0000);
    @(posedge i_clk_sys);
    chk("oe idle", 16'h0003, {o_strobe_oe, o_addr_oe});
  endtask : t_control
  // each quarter has its own wait count, lowest quarter in the top nibble
  task automatic t_wait();
    bus(1, OFS_MEM_WAIT, 16'h3204);
    for (int i = 0; i < 4; i++) begin
      u_ssc_cpu_model.run(1, {i[1:0], 14'h0000}, 0, 0, n, tmo, pe);
      chk("wait edges", 16'(((16'h3204 >> (12 - 4 * i)) & 15) + 3), 16'(n));
    end
  endtask : t_wait
  task automatic t_parity();
    bus(1, OFS_CONTROL, 16'h8000);
    u_ssc_cpu_model.run(1, 16'h0123, 16'h0001, 0, n, tmo, pe);
    chk("even err", 16'h0001, {15'h0000, pe});
    bus(0, OFS_FIRST_FAIL, 0); chk("first fail", 16'h0123, q);
    bus(1, OFS_CONTROL, 16'h8800);
    u_ssc_cpu_model.run(1, 16'h0123, 16'h0001, 0, n, tmo, pe);
    chk("odd ok", 16'h0000, {15'h0000, pe});
  endtask : t_parity
  // clock field 1 makes the fast tick one cycle, so the watchdog ends early
  task automatic t_timers();
    bus(1, OFS_WATCHDOG, 16'h0005);
    bus(1, OFS_TIMING, 16'h0680);
    u_ssc_cpu_model.run(0, 16'h1000, 0, 0, n, tmo, pe);
    chk("timeout", 16'h0001, {15'h0000, tmo});
    chk("limit", 16'h0001, {15'h0000, n >= 64 && n <= 68});
    bus(0, OFS_STATUS, 0); chk("flags", 16'h0180, q & 16'h0180);
  endtask : t_timers
  // faults are seen through the first-failure capture, re-armed by each read
  task automatic t_fault();
    bus(0, OFS_FIRST_FAIL, 0);
    bus(1, OFS_UNIMPL, 16'h2300);
    bus(1, OFS_CONTROL, 16'h0020);
    u_ssc_cpu_model.run(1, 16'h2468, 0, 0, n, tmo, pe);
    bus(0, OFS_FIRST_FAIL, 0); chk("unimpl", 16'h2468, q);
    bus(1, OFS_IN_CMD, 16'h0004);
    bus(1, OFS_CONTROL, 16'h0008);
    u_ssc_cpu_model.run(0, 16'h0005, 0, 0, n, tmo, pe);
    bus(0, OFS_FIRST_FAIL, 0); chk("illegal", 16'h0005, q);
  endtask : t_fault
  task automatic t_bist();
    @(posedge i_clk_sys);
    bist <= 1'b1;
    icv <= 1'b1;
    @(posedge i_clk_sys);
    icv <= 1'b0;
    bus(0, OFS_STATUS, 0); chk("status", 16'hE001, q);
  endtask : t_bist
  task automatic close_out();
    $display("mismatches %0d samples_checked %0d", mismatches, samples_checked);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : close_out
  initial begin
    i_clk_sys = 0;
    forever #4 i_clk_sys = ~i_clk_sys;
  end
  // hang guard well above the few hundred cycles the run needs
  always @(posedge i_clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      close_out();
    end
  end
  initial begin
    {rd, wr, bist, icv, adr, wdat, mismatches, samples_checked, cycles} = 0;
    i_rst_n = 0;
    repeat (6) @(posedge i_clk_sys);
    i_rst_n <= 1;
    t_reset();
    t_control();
    t_wait();
    t_parity();
    t_timers();
    t_fault();
    t_bist();
    close_out();
  end
endmodule : test_ssc_regs
